// *** hw/ebr_top.sv ***
// Embedded memory block: array, port options, FIFO control and Wishbone setup
`timescale 1ns/10ps
module ebr_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Input side from user logic
  input  wire logic        wr_req,
  input  wire logic        blk_sel,
  input  wire logic [10:0] addr,
  input  wire logic [7:0]  din,
  input  wire logic [10:0] rd_addr,
  input  wire logic        rd_req,
  // Output-side clock pin
  input  wire logic        rd_clk,
  // Output side
  output logic      [7:0]  rd_data,
  output logic             fifo_empty,
  output logic             fifo_full
);
  logic [7:0]  ctrl_q;
  logic [10:0] lda_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic [10:0] wa_q;
  logic        we_q;
  logic [7:0]  din_q;
  logic [10:0] ra_q;
  logic [7:0]  dout_q;
  logic [10:0] wptr_q;
  logic [10:0] rptr_q;
  logic [11:0] cnt_q;
  logic [7:0]  rd_word;
  logic [7:0]  ld_word;
  logic        oclk_rise;

  // Configuration fields
  wire [1:0] mode  = ctrl_q[ebr_pkg::CTRL_MODE +: 2];
  wire [1:0] shape = ctrl_q[ebr_pkg::CTRL_SHAPE +: 2];
  wire       rdin  = ctrl_q[ebr_pkg::CTRL_RDIN];
  wire       rdout = ctrl_q[ebr_pkg::CTRL_RDOUT];
  wire       radr  = ctrl_q[ebr_pkg::CTRL_RADR];
  wire       oclk  = ctrl_q[ebr_pkg::CTRL_OCLK];

  wire is_rom  = (mode == ebr_pkg::MODE_ROM);
  wire is_dp   = (mode == ebr_pkg::MODE_DPRAM);
  wire is_fifo = (mode == ebr_pkg::MODE_FIFO);
  wire [10:0] amask = ebr_pkg::addr_mask(shape);

  // Bus decode
  wire bus_req  = wb_cyc_i & wb_stb_i & ~ack_q;
  wire bus_wr   = bus_req & wb_we_i;
  wire sel_ctrl = (wb_adr_i == ebr_pkg::ADR_CTRL);
  wire sel_lda  = (wb_adr_i == ebr_pkg::ADR_LDA);
  wire sel_ldd  = (wb_adr_i == ebr_pkg::ADR_LDD);
  wire sel_stat = (wb_adr_i == ebr_pkg::ADR_STAT);
  wire ld_wr    = bus_wr & sel_ldd & wb_sel_i[0];

  // Input-side capture; write request is plain user logic
  wire        usr_we = wr_req & blk_sel;
  wire [10:0] a_eff  = radr ? wa_q : (addr & amask);
  wire        we_eff = radr ? we_q : usr_we;
  wire [7:0]  d_eff  = rdin ? din_q : din;
  wire [10:0] ra_src = (is_dp ? rd_addr : addr) & amask;
  wire [10:0] ra_eff = radr ? ra_q : ra_src;

  // FIFO bookkeeping
  wire [11:0] depth = {1'b0, amask} + 12'h001;
  wire        full  = (cnt_q == depth);
  wire        empty = (cnt_q == 12'h000);
  wire        push  = is_fifo & usr_we & ~full;
  wire        pop   = is_fifo & rd_req & ~empty;

  // Bus load wins the single write port; a colliding user write is dropped
  wire        usr_wr = is_fifo ? push : (we_eff & ~is_rom);
  wire        m_we   = ld_wr | usr_wr;
  wire [10:0] m_wa   = ld_wr ? lda_q : (is_fifo ? wptr_q : a_eff);
  wire [7:0]  m_wd   = ld_wr ? wb_dat_i[7:0] : (is_fifo ? din : d_eff);
  wire [10:0] m_ra   = is_fifo ? rptr_q : ra_eff;

  // Output-side event: own clock pin or every system clock
  wire out_evt = oclk ? oclk_rise : 1'b1;
  wire dout_ld = is_fifo ? pop : out_evt;

  wire [31:0] stat_word = {14'h0000, full, empty, 4'h0, cnt_q};
  wire [31:0] rd_mux =
    sel_ctrl ? {24'h000000, ctrl_q} :
    sel_lda  ? {21'h000000, lda_q} :
    sel_ldd  ? {24'h000000, ld_word} :
    sel_stat ? stat_word : 32'h00000000;

  ebr_mem u_mem (
    .sys_clk (sys_clk),
    .shape   (shape),
    .we      (m_we),
    .wa      (m_wa),
    .wd      (m_wd),
    .ra_a    (m_ra),
    .rd_a    (rd_word),
    .ra_b    (lda_q),
    .rd_b    (ld_word)
  );

  // Output clock pin is foreign, so it is synchronised first
  ebr_sync u_oclk (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .pin     (rd_clk),
    .rise    (oclk_rise)
  );

  // Wishbone slave: one-cycle answer, unmapped reads zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= bus_req;
      dat_q <= bus_req ? rd_mux : dat_q;
    end
  end

  // Configuration and preload address
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= ebr_pkg::CTRL_RST;
      lda_q  <= ebr_pkg::LDA_RST;
    end else begin
      if (bus_wr && sel_ctrl && wb_sel_i[0]) begin
        ctrl_q <= wb_dat_i[7:0];
      end
      if (ld_wr) begin
        lda_q <= 11'(lda_q + 11'h001) & amask;
      end else if (bus_wr && sel_lda) begin
        lda_q[7:0]  <= wb_sel_i[0] ? wb_dat_i[7:0] : lda_q[7:0];
        lda_q[10:8] <= wb_sel_i[1] ? wb_dat_i[10:8] : lda_q[10:8];
      end
    end
  end

  // Input registers capture every edge; bypass muxes pick them or not
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wa_q  <= 11'h000;
      we_q  <= 1'b0;
      din_q <= 8'h00;
      ra_q  <= 11'h000;
    end else begin
      wa_q  <= addr & amask;
      we_q  <= usr_we;
      din_q <= din;
      ra_q  <= ra_src;
    end
  end

  // Output register on output-side events, or on each pop in FIFO mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_q <= 8'h00;
    end else if (dout_ld) begin
      dout_q <= rd_word;
    end
  end

  // FIFO pointers wrap at the shape's depth
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_q <= 11'h000;
      rptr_q <= 11'h000;
      cnt_q  <= 12'h000;
    end else if (!is_fifo) begin
      wptr_q <= 11'h000;
      rptr_q <= 11'h000;
      cnt_q  <= 12'h000;
    end else begin
      wptr_q <= push ? (11'(wptr_q + 11'h001) & amask) : wptr_q;
      rptr_q <= pop ? (11'(rptr_q + 11'h001) & amask) : rptr_q;
      cnt_q  <= 12'(cnt_q + {11'h000, push} - {11'h000, pop});
    end
  end

  // Bypassed output follows the read address combinationally
  assign rd_data    = rdout ? dout_q : rd_word;
  assign fifo_empty = empty;
  assign fifo_full  = full;
  assign wb_ack_o   = ack_q;
  assign wb_dat_o   = dat_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_plain_write;
    usr_we && mode == ebr_pkg::MODE_RAM && !radr && !rdin && !rdout && !oclk && !ld_wr;
  endsequence

  a_bus_answer: assert property (s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");

  a_ram_write_lands: assert property (s_plain_write ##1 (!radr && !is_dp && !m_we && ctrl_q == $past(ctrl_q)
      && (addr & amask) == ($past(addr) & amask)) |-> rd_data == ($past(din) & (8'hFF >> (4'h8 - ebr_pkg::word_w(shape)))))
    else $error("written word not read back");

  a_rom_locked: assert property (is_rom && !ld_wr |-> !m_we)
    else $error("rom written by user port");

  a_fifo_no_overrun: assert property (fifo_full |-> !push)
    else $error("push into full fifo");

  a_fifo_count: assert property (is_fifo && push && !pop |=> !is_fifo || cnt_q == $past(cnt_q) + 12'h001)
    else $error("fifo count not advanced");

  a_dout_delay: assert property (rdout && !is_fifo && out_evt |=> dout_q == $past(rd_word))
    else $error("output register missed event");

  a_width_limit: assert property ((rd_data & ~(8'hFF >> (4'h8 - ebr_pkg::word_w(shape)))) == 8'h00)
    else $error("data above word width");

  // Shape must hold across the capture edge, or the mask differs
  a_addr_reg: assert property (radr ##1 $stable(ctrl_q) |-> a_eff == ($past(addr) & amask)
      && we_eff == $past(usr_we))
    else $error("address register not one cycle");

  a_oclk_hold: assert property (oclk && rdout && !is_fifo && !oclk_rise |=> $stable(dout_q))
    else $error("output moved without its clock");

  a_cascade_sel: assert property (!blk_sel && !ld_wr && !radr |-> !m_we)
    else $error("write with block deselected");
endmodule : ebr_top

// *** hw/ebr_pkg.sv ***
// Constants, field layout and helpers of the embedded memory block
// Behaviour
// - Block holds exactly 2,048 storage bits.
// - Mode is RAM, ROM, dual-port or FIFO.
// - Shapes 256x8, 512x4, 1024x2, 2048x1.
// - Internal write pulse, timed by clock edge.
// - Output side may use separate clock.
// - Data-in, data-out, address/write registers selectable.
// - ROM contents preloaded, read as lookup.
// - Side-by-side blocks share address for width.
// - Cascade for depth, same timing to 2,048.
package ebr_pkg;
  localparam int unsigned BITS      = 2048;
  localparam int unsigned AW        = 11;
  localparam int unsigned DW        = 8;

  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_LDA    = 8'h04;
  localparam logic [7:0] ADR_LDD    = 8'h08;
  localparam logic [7:0] ADR_STAT   = 8'h0C;

  localparam int unsigned CTRL_MODE  = 0;
  localparam int unsigned CTRL_SHAPE = 2;
  localparam int unsigned CTRL_RDIN  = 4;
  localparam int unsigned CTRL_RDOUT = 5;
  localparam int unsigned CTRL_RADR  = 6;
  localparam int unsigned CTRL_OCLK  = 7;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [10:0] LDA_RST    = 11'h000;

  localparam int unsigned STAT_EMPTY = 16;
  localparam int unsigned STAT_FULL  = 17;

  localparam logic [1:0] MODE_RAM   = 2'h0;
  localparam logic [1:0] MODE_ROM   = 2'h1;
  localparam logic [1:0] MODE_DPRAM = 2'h2;
  localparam logic [1:0] MODE_FIFO  = 2'h3;

  // Word width in bits: 8, 4, 2 or 1
  function automatic logic [3:0] word_w(input logic [1:0] shape);
    return 4'h8 >> shape;
  endfunction : word_w

  // Valid address bits: 8, 9, 10 or 11
  function automatic logic [10:0] addr_mask(input logic [1:0] shape);
    return 11'h7FF >> (2'h3 - shape);
  endfunction : addr_mask

  // First storage bit of a word
  function automatic logic [10:0] bit_base(input logic [10:0] a, input logic [1:0] shape);
    return 11'((a & addr_mask(shape)) << (2'h3 - shape));
  endfunction : bit_base
endpackage : ebr_pkg

// *** hw/ebr_sync.sv ***
// Two-stage synchroniser with rising-edge pulse for the output clock pin
`timescale 1ns/10ps
module ebr_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Asynchronous level in, edge out
  input  wire logic pin,
  output logic      rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q & ~s3_q;
endmodule : ebr_sync

// *** hw/ebr_mem.sv ***
// Storage array of the block with one write port and two read ports
`timescale 1ns/10ps
module ebr_mem (
  // Clock
  input  wire logic        sys_clk,
  // Organisation
  input  wire logic [1:0]  shape,
  // Write port
  input  wire logic        we,
  input  wire logic [10:0] wa,
  input  wire logic [7:0]  wd,
  // Read ports
  input  wire logic [10:0] ra_a,
  output logic      [7:0]  rd_a,
  input  wire logic [10:0] ra_b,
  output logic      [7:0]  rd_b
);
  // All bits usable, none lost to control
  logic mem_q [0:ebr_pkg::BITS-1];

  wire [10:0] wbase = ebr_pkg::bit_base(wa, shape);
  wire [10:0] abase = ebr_pkg::bit_base(ra_a, shape);
  wire [10:0] bbase = ebr_pkg::bit_base(ra_b, shape);
  wire [3:0]  width = ebr_pkg::word_w(shape);

  // Write lands in the clock edge itself; no external strobe timing
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < ebr_pkg::DW; i++) begin
      if (we && 4'(i) < width) begin
        mem_q[11'(wbase + 11'(i))] <= wd[i];
      end
    end
  end

  // Unused upper data bits read as zero
  for (genvar g = 0; g < ebr_pkg::DW; g++) begin : g_lane
    assign rd_a[g] = (4'(g) < width) ? mem_q[11'(abase + 11'(g))] : 1'b0;
    assign rd_b[g] = (4'(g) < width) ? mem_q[11'(bbase + 11'(g))] : 1'b0;
  end
endmodule : ebr_mem

// *** testbench/ebr_user.sv ***
// Behavioural model of the user logic on the block's input side and output clock pin
`timescale 1ns/10ps
module ebr_user (
  // Clock
  input  wire logic        sys_clk,
  // Input side of the block and its output-side clock pin
  output logic             wr_req,
  output logic             blk_sel,
  output logic      [10:0] addr,
  output logic      [7:0]  din,
  output logic      [10:0] rd_addr,
  output logic             rd_req,
  output logic             rd_clk
);
  initial begin
    wr_req  = 1'b0;
    blk_sel = 1'b0;
    addr    = 11'h000;
    din     = 8'h00;
    rd_addr = 11'h000;
    rd_req  = 1'b0;
    rd_clk  = 1'b0;
  end

  // One write request, held for its taking edge only
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr    <= a;
    din     <= d;
    wr_req  <= 1'b1;
    blk_sel <= 1'b1;
    @(posedge sys_clk);
    wr_req  <= 1'b0;
  endtask : wr

  // Write offered while the block is deselected; it must be dropped
  task automatic wr_desel(input logic [10:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr    <= a;
    din     <= d;
    wr_req  <= 1'b1;
    blk_sel <= 1'b0;
    @(posedge sys_clk);
    wr_req  <= 1'b0;
    blk_sel <= 1'b1;
  endtask : wr_desel

  // One output-clock pulse, idle low outside it
  task automatic out_tick;
    @(posedge sys_clk);
    rd_clk <= 1'b1;
    @(posedge sys_clk);
    rd_clk <= 1'b0;
  endtask : out_tick

  task automatic pop;
    @(posedge sys_clk);
    rd_req <= 1'b1;
    @(posedge sys_clk);
    rd_req <= 1'b0;
  endtask : pop

  task automatic look_at(input logic [10:0] a, input logic [10:0] ra);
    @(posedge sys_clk);
    addr    <= a;
    rd_addr <= ra;
  endtask : look_at
endmodule : ebr_user

// *** testbench/tb_ebr_top.sv ***
// Self-checking bench of the embedded memory block
`timescale 1ns/10ps
module tb_ebr_top;
  logic        sys_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        wr_req, blk_sel, rd_req, rd_clk;
  logic [10:0] addr, rd_addr, a;
  logic [7:0]  din, rd_data, d, m;
  logic        fifo_empty, fifo_full;
  logic        rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  string       nm_q[$];
  int          fail_count = 0;
  int          check_count = 0;
  event        look_ev;
  event        flag_ev;

  always #5 sys_clk = ~sys_clk;

  ebr_top i_ebr_top (.sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wr_req(wr_req), .blk_sel(blk_sel), .addr(addr), .din(din), .rd_addr(rd_addr),
    .rd_req(rd_req), .rd_clk(rd_clk), .rd_data(rd_data), .fifo_empty(fifo_empty), .fifo_full(fifo_full));
  ebr_user i_ebr_user (.sys_clk(sys_clk), .wr_req(wr_req), .blk_sel(blk_sel), .addr(addr), .din(din),
    .rd_addr(rd_addr), .rd_req(rd_req), .rd_clk(rd_clk));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic compare(input logic [31:0] seen);
    check_count++;
    if (exp_q.size() == 0 || seen !== exp_q[0]) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm_q[0], exp_q[0], seen);
    end
    void'(exp_q.pop_front());
    void'(nm_q.pop_front());
  endtask : compare

  // Bus reads are judged at the ack edge, array reads on request
  always @(posedge sys_clk) begin
    if (rd_pend && wb_ack_o === 1'b1) begin
      rd_pend = 1'b0;
      compare(wb_dat_o);
    end
  end
  always @(look_ev) compare({24'h0, rd_data});
  always @(flag_ev) compare({30'h0, fifo_full, fifo_empty});

  task automatic bus(input logic we, input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] s);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= ad;
    wb_dat_i <= dt;
    wb_sel_i <= s;
    rd_pend = !we;
    // No cycle limit here: only the watchdog ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task automatic rd_reg(input logic [7:0] ad, input logic [31:0] v);
    exp_q.push_back(v);
    nm_q.push_back("bus read");
    bus(1'b0, ad, 32'h0, 4'hF);
  endtask : rd_reg

  // Let the edge settle before sampling the array output
  task automatic look(input logic [31:0] v);
    #1;
    exp_q.push_back(v);
    nm_q.push_back("rd_data");
    -> look_ev;
  endtask : look

  task automatic flags(input logic [31:0] v);
    #1;
    exp_q.push_back(v);
    nm_q.push_back("fifo flags");
    -> flag_ev;
  endtask : flags

  initial begin
    #100000;
    fail_count++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h502E));
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd_reg(ebr_pkg::ADR_CTRL, 32'h0);
    rd_reg(8'h10, 32'h0);
    d = 8'($urandom);
    bus(1'b1, ebr_pkg::ADR_CTRL, {30'h0, ebr_pkg::MODE_ROM}, 4'h1);
    bus(1'b1, ebr_pkg::ADR_LDA, 32'h5, 4'h3);
    bus(1'b1, ebr_pkg::ADR_LDD, {24'h0, d}, 4'h1);
    bus(1'b1, ebr_pkg::ADR_LDA, 32'h5, 4'h3);
    rd_reg(ebr_pkg::ADR_LDD, {24'h0, d});
    i_ebr_user.wr(11'h5, ~d);
    look({24'h0, d});
    for (int s = 0; s < 4; s++) begin
      a = 11'($urandom);
      d = 8'($urandom);
      m = 8'hFF >> (8 - (8 >> s));
      bus(1'b1, ebr_pkg::ADR_CTRL, 32'(s << 2), 4'h1);
      i_ebr_user.wr(a, d);
      i_ebr_user.look_at(a & 11'(11'h7FF >> (3 - s)), 11'h0);
      look({24'h0, d & m});
    end
    bus(1'b1, ebr_pkg::ADR_CTRL, {30'h0, ebr_pkg::MODE_DPRAM}, 4'h1);
    i_ebr_user.wr(11'h21, d);
    i_ebr_user.wr_desel(11'h21, ~d);
    i_ebr_user.look_at(11'h0, 11'h21);
    look({24'h0, d});
    bus(1'b1, ebr_pkg::ADR_CTRL, 32'h20, 4'h1);
    i_ebr_user.wr(11'h33, d);
    i_ebr_user.wr(11'h33, ~d);
    look({24'h0, d});
    @(posedge sys_clk);
    look({24'h0, ~d});
    bus(1'b1, ebr_pkg::ADR_CTRL, 32'h50, 4'h1);
    i_ebr_user.wr(11'h33, d ^ 8'h5A);
    look({24'h0, ~d});
    @(posedge sys_clk);
    look({24'h0, d ^ 8'h5A});
    bus(1'b1, ebr_pkg::ADR_CTRL, 32'hA0, 4'h1);
    i_ebr_user.wr(11'h33, d ^ 8'hC3);
    look({24'h0, d ^ 8'h5A});
    i_ebr_user.out_tick();
    repeat (2) @(posedge sys_clk);
    look({24'h0, d ^ 8'hC3});
    bus(1'b1, ebr_pkg::ADR_CTRL, {30'h0, ebr_pkg::MODE_FIFO}, 4'h1);
    i_ebr_user.wr(11'h0, d);
    i_ebr_user.wr(11'h0, ~d);
    rd_reg(ebr_pkg::ADR_STAT, 32'h2);
    look({24'h0, d});
    i_ebr_user.pop();
    look({24'h0, ~d});
    i_ebr_user.pop();
    rd_reg(ebr_pkg::ADR_STAT, 32'h10000);
    flags(32'h1);
    for (int i = 0; i < 256; i++) begin
      i_ebr_user.wr(11'h0, 8'($urandom));
    end
    flags(32'h2);
    i_ebr_user.wr(11'h0, d);
    rd_reg(ebr_pkg::ADR_STAT, 32'h20100);
    repeat (2) @(posedge sys_clk);
    complete_run();
  end
endmodule : tb_ebr_top
